// ### rtl/oramx_dec_if.sv
// decoded instruction fields, decoder to execute stage
interface oramx_dec_if;
	import oramx_pkg::*;
	logic               or_lit;    // literal or
	logic               load_lit;  // literal load
	logic               or_file;   // register or
	logic               move;      // register move
	logic               store;     // accumulator store
	logic               dest;      // destination bit
	logic [ADDR_W-1:0]  addr;      // file address
	logic [DATA_W-1:0]  lit;       // eight bit literal

	modport dec (output or_lit, load_lit, or_file, move, store, dest,
		addr, lit);
	modport exe (input or_lit, load_lit, or_file, move, store, dest,
		addr, lit);
endinterface

// ### rtl/oramx_decode.sv
// pure combinational opcode decode, qualified by valid
module oramx_decode
	import oramx_pkg::*;
(
	input  wire logic [INSTR_W-1:0] i_instr,  // instruction word
	input  wire logic               i_valid,  // word present this cycle
	oramx_dec_if.dec                dec       // decoded fields
);

	// ----------------------------------------------------------------
	// pattern matches
	// ----------------------------------------------------------------
	assign dec.or_lit   = i_valid && (i_instr[11:8] == OP_OR_LIT);
	assign dec.load_lit = i_valid && (i_instr[11:8] == OP_LOAD_LIT);
	assign dec.or_file  = i_valid && (i_instr[11:6] == OP_OR_FILE);
	assign dec.move     = i_valid && (i_instr[11:6] == OP_MOVE);
	assign dec.store    = i_valid && (i_instr[11:5] == OP_STORE);

	// ----------------------------------------------------------------
	// operand fields
	// ----------------------------------------------------------------
	assign dec.dest = i_instr[DEST_BIT];
	assign dec.addr = i_instr[ADDR_W-1:0];
	assign dec.lit  = i_instr[DATA_W-1:0];

endmodule

// ### rtl/oramx_exec.sv
// executes the or / move group in one instruction cycle each
module oramx_exec
	import oramx_pkg::*;
(
	input  wire logic               i_clk,          // core clock
	input  wire logic               i_rstn,         // async reset, low
	input  wire logic [INSTR_W-1:0] i_instr,        // instruction word
	input  wire logic               i_valid,        // one word per cycle
	input  wire logic [ADDR_W-1:0]  i_peek_addr,    // file peek address
	output logic      [DATA_W-1:0]  o_acc,          // accumulator
	output logic                    o_zero,         // zero flag
	output logic                    o_done,         // instruction retired
	output logic                    o_file_we,      // file written
	output logic      [ADDR_W-1:0]  o_file_addr,    // written address
	output logic      [DATA_W-1:0]  o_file_wdata,   // written value
	output logic      [DATA_W-1:0]  o_peek_data     // peeked file value
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	oramx_dec_if dec_if ();             // decoded fields

	oramx_decode u_decode (
		.i_instr (i_instr),
		.i_valid (i_valid),
		.dec     (dec_if.dec)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] acc_q;           // accumulator
	logic              zero_q;          // zero flag
	logic              done_q;          // retire pulse
	logic              fwe_q;           // file write report
	logic [ADDR_W-1:0] faddr_q;         // file write address report
	logic [DATA_W-1:0] fwdata_q;        // file write data report
	logic [DATA_W-1:0] peek_q;          // registered peek
	logic [DATA_W-1:0] file_q [FILE_N]; // file register array

	// ----------------------------------------------------------------
	// datapath selection
	// ----------------------------------------------------------------
	wire [DATA_W-1:0] rd_w = file_q[dec_if.addr];      // addressed file
	wire [DATA_W-1:0] lit_w = dec_if.lit;               // literal operand
	wire [DATA_W-1:0] or_lit_w = acc_q | lit_w;
	wire [DATA_W-1:0] or_file_w = acc_q | rd_w;
	wire              routed_w = dec_if.or_file || dec_if.move;
	wire [DATA_W-1:0] res_w =
		dec_if.or_lit   ? or_lit_w  :
		dec_if.load_lit ? lit_w     :
		dec_if.or_file  ? or_file_w :
		dec_if.move     ? rd_w      :
		acc_q;
	// dest 0 to accumulator, 1 back to file
	wire wr_acc_w = dec_if.or_lit || dec_if.load_lit ||
		(routed_w && !dec_if.dest);
	wire wr_file_w = dec_if.store ||
		(routed_w && dec_if.dest);
	// store and literal load leave the flag alone
	wire zupd_w = dec_if.or_lit || routed_w;
	wire zres_w = (res_w == '0);
	wire claim_w = zupd_w || dec_if.load_lit || dec_if.store;

	// ----------------------------------------------------------------
	// accumulator and zero flag
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			acc_q  <= ACC_RST;
			zero_q <= ZERO_RST;
		end else begin
			if (wr_acc_w) begin
				acc_q <= res_w;
			end
			if (zupd_w) begin
				zero_q <= zres_w;
			end
		end
	end

	// ----------------------------------------------------------------
	// file register array
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < FILE_N; i++) begin
				file_q[i] <= FILE_RST;
			end
		end else if (wr_file_w) begin
			file_q[dec_if.addr] <= res_w;
		end
	end

	// ----------------------------------------------------------------
	// retire and write reports, one cycle per instruction
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			done_q   <= 1'b0;
			fwe_q    <= 1'b0;
			faddr_q  <= '0;
			fwdata_q <= '0;
			peek_q   <= FILE_RST;
		end else begin
			done_q   <= claim_w;
			fwe_q    <= wr_file_w;
			faddr_q  <= dec_if.addr;
			fwdata_q <= res_w;
			peek_q   <= file_q[i_peek_addr];
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_acc        = acc_q;
	assign o_zero       = zero_q;
	assign o_done       = done_q;
	assign o_file_we    = fwe_q;
	assign o_file_addr  = faddr_q;
	assign o_file_wdata = fwdata_q;
	assign o_peek_data  = peek_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// literal or lands in accumulator with zero flag
	a_or_lit_result: assert property (
		dec_if.or_lit |=> acc_q == $past(acc_q | dec_if.lit) &&
			zero_q == (acc_q == 8'h00) && !fwe_q)
		else $error("literal or result wrong");

	// register or goes where the dest bit says
	a_or_file_route: assert property (
		dec_if.or_file |=> fwe_q == $past(dec_if.dest) &&
			fwdata_q == $past(or_file_w) && done_q)
		else $error("register or routing wrong");

	// dest 0 leaves file alone, loads accumulator
	a_dest_acc_only: assert property (
		routed_w && !dec_if.dest |=> !fwe_q && acc_q == $past(res_w))
		else $error("dest 0 not to accumulator");

	// dest 1 keeps accumulator, writes file
	a_dest_file_only: assert property (
		routed_w && dec_if.dest |=> fwe_q && $stable(acc_q))
		else $error("dest 1 not to file");

	// move sets zero from the moved value
	a_move_zero_test: assert property (
		dec_if.move |=> zero_q == ($past(rd_w) == 8'h00) &&
			fwdata_q == $past(rd_w))
		else $error("register move zero wrong");

	// store writes accumulator, flags untouched
	a_store_no_flags: assert property (
		dec_if.store |=> $stable(zero_q) && fwe_q &&
			fwdata_q == $past(acc_q) && o_file_addr == $past(dec_if.addr))
		else $error("accumulator store wrong");

	// every claimed word retires the next cycle only
	a_one_cycle_retire: assert property (
		claim_w |=> done_q && (fwe_q || acc_q == $past(res_w)))
		else $error("retire timing wrong");

	// no claimed word, no retire, no flag move
	a_idle_quiet: assert property (
		!claim_w |=> !done_q && !fwe_q && $stable(zero_q))
		else $error("idle cycle changed state");

	c_or_lit_zero:  cover property (dec_if.or_lit ##1 zero_q);
	c_move_to_file: cover property (dec_if.move && dec_if.dest);
	c_store_then_or: cover property (dec_if.store ##1 dec_if.or_file);

endmodule

// ### rtl/oramx_pkg.sv
package oramx_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int unsigned INSTR_W = 12;   // instruction word width
	localparam int unsigned DATA_W  = 8;    // data path width
	localparam int unsigned ADDR_W  = 5;    // file address field width
	localparam int unsigned FILE_N  = 32;   // file registers addressable

	// ----------------------------------------------------------------
	// opcode fields and patterns
	// ----------------------------------------------------------------
	localparam int unsigned DEST_BIT = 5;         // destination select bit
	localparam logic [3:0] OP_OR_LIT   = 4'hd;    // bits 11:8 literal or
	localparam logic [3:0] OP_LOAD_LIT = 4'hc;    // bits 11:8 literal load
	localparam logic [5:0] OP_OR_FILE  = 6'h04;   // bits 11:6 register or
	localparam logic [5:0] OP_MOVE     = 6'h08;   // bits 11:6 register move
	localparam logic [6:0] OP_STORE    = 7'h01;   // bits 11:5 acc store

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ACC_RST  = 8'h00;      // accumulator after reset
	localparam logic       ZERO_RST = 1'b0;       // zero flag after reset
	localparam logic [7:0] FILE_RST = 8'h00;      // file cells after reset

endpackage

// ### test/oramx_exec_bench.sv
module oramx_exec_bench import oramx_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// design hookup and model state
	// ------------------------------------------------------------
	logic               i_clk, i_rstn, i_valid;
	logic [INSTR_W-1:0] i_instr;         // word under test
	logic [ADDR_W-1:0]  i_peek_addr;     // file cell to look at
	logic [DATA_W-1:0]  o_acc, o_file_wdata, o_peek_data;
	logic               o_zero, o_done, o_file_we;
	logic [ADDR_W-1:0]  o_file_addr;
	logic [DATA_W-1:0]  m_acc;           // model accumulator
	logic               m_zero;          // model zero flag
	logic [DATA_W-1:0]  m_file [FILE_N]; // model file array
	logic [22:0]        exp_q [$];       // acc,zero,we,addr,wdata notes
	logic [31:0]        seed;            // xorshift state
	logic [INSTR_W-1:0] w;               // random word
	int                 miscompares, checked;

	oramx_exec oramx_exec_i (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_instr(i_instr), .i_valid(i_valid), .i_peek_addr(i_peek_addr),
		.o_acc(o_acc), .o_zero(o_zero), .o_done(o_done),
		.o_file_we(o_file_we), .o_file_addr(o_file_addr),
		.o_file_wdata(o_file_wdata), .o_peek_data(o_peek_data));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// counts one comparison, reports a mismatch at once
	task automatic cmp(input string nm, input logic [22:0] e, g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// drives one word at the falling edge and notes its result
	task automatic issue(input logic [11:0] x, input logic v);
		logic [7:0] r;
		logic       hit;
		logic       we;
		r = 8'h00;
		hit = v;
		we = 1'b0;
		@(negedge i_clk);
		i_instr = x;
		i_valid = v;
		if (!v) hit = 1'b0;
		else if (x[11:8] == OP_OR_LIT) begin
			m_acc = m_acc | x[7:0];
			m_zero = (m_acc == 8'h00);
		end else if (x[11:8] == OP_LOAD_LIT) m_acc = x[7:0];
		else if (x[11:6] == OP_OR_FILE || x[11:6] == OP_MOVE) begin
			r = m_file[x[4:0]] | (x[9] ? 8'h00 : m_acc);
			m_zero = (r == 8'h00);
			we = x[DEST_BIT];
			if (we) m_file[x[4:0]] = r;
			else m_acc = r;
		end else if (x[11:5] == OP_STORE) begin
			r = m_acc;
			we = 1'b1;
			m_file[x[4:0]] = r;
		end else hit = 1'b0;
		if (hit) exp_q.push_back({m_acc, m_zero, we, x[4:0], r});
	endtask

	task automatic test_done();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock, monitor, watchdog
	// ------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// each retired word takes the oldest note; no pulse without one
	always @(negedge i_clk) begin
		logic [22:0] e, g;
		if (i_rstn === 1'b1 && o_done === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 23'h7f_ffff;
			g = {o_acc, o_zero, o_file_we, o_file_addr, o_file_wdata};
			if (e[13] === 1'b0) g[12:0] = e[12:0];
			cmp("retired result", e, g);
		end
	end

	initial begin
		#200000;
		miscompares++;
		test_done();
	end

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		i_rstn = 1'b0;
		i_valid = 1'b0;
		i_instr = 12'h000;
		i_peek_addr = 5'h00;
		m_acc = ACC_RST;
		m_zero = ZERO_RST;
		seed = 32'ha0ea;
		foreach (m_file[a]) m_file[a] = FILE_RST;
		repeat (10) @(posedge i_clk);
		@(negedge i_clk);
		i_rstn = 1'b1;
		issue(12'hd00, 1'b1); // zero result sets the flag
		issue(12'hc9a, 1'b1);
		issue(12'hd35, 1'b1); // 9a or 35 gives bf
		issue(12'h023, 1'b1); // store keeps zero flag
		issue(12'h123, 1'b1); // or back into cell 3
		issue(12'h203, 1'b1); // cell 3 into acc
		issue(12'h23f, 1'b1); // zero test of cell 31
		issue(12'hd00, 1'b0); // not valid, nothing retires
		issue(12'h000, 1'b1); // foreign word ignored
		$display("directed words done");
		for (int n = 0; n < 400; n++) begin
			seed = xs(seed);
			case (seed[2:0])
				3'd0: w = {OP_OR_LIT, seed[15:8] & seed[23:16]};
				3'd1: w = {OP_LOAD_LIT, seed[8] ? 8'h00 : seed[23:16]};
				3'd2: w = {OP_OR_FILE, seed[13:8]};
				3'd3: w = {OP_MOVE, seed[13:8]};
				3'd4: w = {OP_STORE, seed[12:8]};
				default: w = seed[27:16];
			endcase
			issue(w, seed[2:0] != 3'd7);
		end
		issue(12'h000, 1'b0);
		$display("random words done");
		for (int a = 0; a < FILE_N; a++) begin
			@(negedge i_clk);
			i_peek_addr = 5'(a);
			@(negedge i_clk);
			cmp("file cell", 23'(m_file[a]), 23'(o_peek_data));
		end
		cmp("notes left", 23'h00_0000, 23'(exp_q.size()));
		$display("file contents done");
		test_done();
	end
endmodule
